// >>> sub_bus_regs.vh
// Purpose: line positions, operation codes and pin-side constants for the
//          memory end of the local multiplexed sub bus
// Assumes: included by the memory slave only
// Notes:   definitions only, no logic
`ifndef SUB_BUS_REGS_VH
`define SUB_BUS_REGS_VH

// width of the shared address/data lines
`define SB_W 24
// address phase: word address bits 0..11 ride on lines 0..11
`define SB_ALO_MSB 11
`define SB_ALO_LSB 0
// address phase: word address bits 12..17 ride on lines 18..23
`define SB_AHI_MSB 23
`define SB_AHI_LSB 18
// address phase: operation code bits and read/write level
`define SB_A18 15
`define SB_A19 16
`define SB_RW 17
// data phase: data lines and the two odd parity lines
`define SB_DAT_MSB 15
`define SB_DAT_LSB 0
`define SB_LPAR 16
`define SB_UPAR 17
// byte boundaries inside the data field
`define SB_LO_MSB 7
`define SB_HI_LSB 8
// data phase: function select and function control lines
`define SB_FSEL_MSB 20
`define SB_FSEL_LSB 18
`define SB_FCTL_MSB 23
`define SB_FCTL_LSB 21
// output enable patterns: memory drives data and parity only
`define SB_OE_DATA 24'h03ffff
`define SB_OE_NONE 24'h000000
// operation codes from address bits 19,18
`define OP_NONE 2'h0
`define OP_LOW 2'h1
`define OP_UP 2'h2
`define OP_WORD 2'h3
// word address width on the bus
`define WADDR_W 18
// synchroniser reset value for the control pins: all strobes released
`define CTL_IDLE 4'hf
// byte enable patterns for the commit stream
`define BE_LOW 2'h1
`define BE_UP 2'h2
`define BE_WORD 2'h3

`endif

// >>> sub_bus_memory.v
// Purpose: memory module end of the local multiplexed sub bus
// Assumes: bus pins arrive asynchronous to clk_sys and are double synced;
//          strobes and reply are active low on the wire
// Notes:   accepted writes update local storage and are also pushed into a
//          two-entry buffer toward the user side; a full buffer holds off
//          the data-phase reply so no word is lost
//
// Function
// - memory transfer: address phase then data phase
// - function transfers carry no address phase
// - lines twelve to fourteen ignored during address
// - rw plus bits 19,18 select byte/word operation
// - odd parity per byte, always both valid
// - top six lines: function select and control
// - matching memory replies at once, latches address
// - data strobe; memory or master drives data
// - memory replies on accept; master releases strobe
// - function strobe plus six lines address function
// - address strobe and reply on phase-four edges
`timescale 1ns/100ps
`include "sub_bus_regs.vh"

module sub_bus_memory #(
   parameter AW = 6,                // local word address width
   parameter [`WADDR_W-1:0] BASE = 18'h00000 // first word answered
) (
   // clock, reset, enable
   input wire clk_sys,
   input wire rstn,
   input wire ce,
   // phase-four master clock, a pin
   input wire phase4_clk,
   // shared lines, three-state
   input wire [`SB_W-1:0] shared_lines_i,
   output reg [`SB_W-1:0] shared_lines_o,
   output reg [`SB_W-1:0] shared_lines_oe,
   // transfer strobes from the master, active low
   input wire address_phase_strobe_n,
   input wire data_strobe_n,
   input wire function_strobe_n,
   // memory reply, open collector
   output reg memory_reply_n_o,
   output reg memory_reply_oe,
   // commit stream of accepted writes
   output reg wr_valid,
   input wire wr_ready,
   output reg [AW-1:0] wr_addr,
   output reg [1:0] wr_be,
   output reg [15:0] wr_data,
   // one-cycle pulse on a write with bad parity
   output reg parity_error
);

   ////////////////////////////////////////////////////////////////////////
   // one-hot states
   localparam [5:0] S_IDLE = 6'h01; // waiting for an address phase
   localparam [5:0] S_ADDR = 6'h02; // address reply on
   localparam [5:0] S_WAIT = 6'h04; // waiting for the data strobe
   localparam [5:0] S_RDRV = 6'h08; // read data settling on the lines
   localparam [5:0] S_HOLD = 6'h10; // write data settling / buffer full
   localparam [5:0] S_ACK = 6'h20;  // data reply on until strobe release
   localparam BW = AW + 2 + 16;     // buffer entry width

   // odd parity bit for one byte
   function odd_par;
      input [7:0] b;
      begin
         odd_par = ~^b;
      end
   endfunction

   // entry packing for the two-entry buffer
   function [BW-1:0] pack;
      input [AW-1:0] a;
      input [1:0] be;
      input [15:0] d;
      begin
         pack = {a, be, d};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // synchronisers: first stage read only by the second
   reg [`SB_W-1:0] sb_s1_q, sb_s2_q;
   reg [3:0] ctl_s1_q, ctl_s2_q; // {phase4, atr_n, dtr_n, fen_n}
   reg ph4_d1_q;                 // delayed copy for the falling edge

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sb_s1_q <= `SB_OE_NONE;
         sb_s2_q <= `SB_OE_NONE;
         ctl_s1_q <= `CTL_IDLE;
         ctl_s2_q <= `CTL_IDLE;
         ph4_d1_q <= 1'b1;
      end else if (ce) begin
         sb_s1_q <= shared_lines_i;
         sb_s2_q <= sb_s1_q;
         ctl_s1_q <= {phase4_clk, address_phase_strobe_n, data_strobe_n,
                      function_strobe_n};
         ctl_s2_q <= ctl_s1_q;
         ph4_d1_q <= ctl_s2_q[3];
      end
   end

   wire atr = ~ctl_s2_q[2];
   wire dtr = ~ctl_s2_q[1];
   wire fen = ~ctl_s2_q[0];
   wire ph4_fall = ph4_d1_q & ~ctl_s2_q[3];

   ////////////////////////////////////////////////////////////////////////
   // address phase decode
   // lines twelve to fourteen are left out of the address on purpose
   wire [`WADDR_W-1:0] bus_addr = {sb_s2_q[`SB_AHI_MSB:`SB_AHI_LSB],
                                   sb_s2_q[`SB_ALO_MSB:`SB_ALO_LSB]};
   wire [1:0] bus_op = {sb_s2_q[`SB_A19], sb_s2_q[`SB_A18]};
   wire bus_rw = sb_s2_q[`SB_RW];
   // the forbidden code gets no reply, so the master falls back elsewhere
   wire op_ok = (bus_op != `OP_NONE);
   wire hit = (bus_addr[`WADDR_W-1:AW] == BASE[`WADDR_W-1:AW]);
   // a function strobe alone is not ours: no address phase means no match
   wire start = atr & ~fen & hit & op_ok & ph4_fall;

   // data phase fields
   wire [7:0] in_lo = sb_s2_q[`SB_LO_MSB:`SB_DAT_LSB];
   wire [7:0] in_hi = sb_s2_q[`SB_DAT_MSB:`SB_HI_LSB];
   wire par_bad = (sb_s2_q[`SB_LPAR] != odd_par(in_lo)) |
                  (sb_s2_q[`SB_UPAR] != odd_par(in_hi));

   ////////////////////////////////////////////////////////////////////////
   // storage and latched address-phase information
   reg [15:0] mem_q [0:(1<<AW)-1];
   reg [5:0] state_q;
   reg [AW-1:0] addr_q;   // word index latched in the address phase
   reg [1:0] op_q;        // byte/word selection
   reg rw_q;              // high means the master writes

   // two-entry buffer: head feeds the ports, tail absorbs a stall
   reg [BW-1:0] tail_q;
   reg tail_valid_q;
   wire buf_full = tail_valid_q;
   wire pop = wr_valid & wr_ready;

   wire [15:0] cur = mem_q[addr_q];
   // byte writes keep the other byte of the stored word
   wire [15:0] merged = {(op_q[1] ? in_hi : cur[`SB_DAT_MSB:`SB_HI_LSB]),
                         (op_q[0] ? in_lo : cur[`SB_LO_MSB:`SB_DAT_LSB])};
   wire push = (state_q == S_HOLD) & ~buf_full;

   ////////////////////////////////////////////////////////////////////////
   // transfer sequencer
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= S_IDLE;
         addr_q <= {AW{1'b0}};
         op_q <= `OP_NONE;
         rw_q <= 1'b0;
         memory_reply_n_o <= 1'b0;
         memory_reply_oe <= 1'b0;
         shared_lines_o <= `SB_OE_NONE;
         shared_lines_oe <= `SB_OE_NONE;
         parity_error <= 1'b0;
      end else if (ce) begin
         parity_error <= 1'b0;
         memory_reply_n_o <= 1'b0; // the wire is only ever pulled low
         case (state_q)
            S_IDLE: begin
               // reply and latch together, on the phase-four edge
               if (start) begin
                  addr_q <= bus_addr[AW-1:0];
                  op_q <= bus_op;
                  rw_q <= bus_rw;
                  memory_reply_oe <= 1'b1;
                  state_q <= S_ADDR;
               end
            end
            S_ADDR: begin
               // reply drops when the address phase ends or data starts
               if (!atr || dtr) begin
                  memory_reply_oe <= 1'b0;
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               // data phase is asynchronous; a linked function strobe may
               // delay it arbitrarily
               if (dtr) begin
                  if (rw_q) begin
                     state_q <= S_HOLD;
                  end else begin
                     shared_lines_o <= {{(`SB_W-`SB_UPAR-1){1'b0}},
                                        odd_par(cur[`SB_DAT_MSB:`SB_HI_LSB]),
                                        odd_par(cur[`SB_LO_MSB:`SB_DAT_LSB]),
                                        cur};
                     // function select/control lines stay released for the
                     // function modules
                     shared_lines_oe <= `SB_OE_DATA;
                     state_q <= S_RDRV;
                  end
               end else if (atr && ph4_fall) begin
                  // a fresh address phase means the old one was dropped
                  state_q <= S_IDLE;
               end
            end
            S_RDRV: begin
               // one cycle of settling before the reply
               memory_reply_oe <= 1'b1;
               state_q <= S_ACK;
            end
            S_HOLD: begin
               // accept only with room in the buffer: back-pressure
               if (!buf_full) begin
                  mem_q[addr_q] <= merged;
                  parity_error <= par_bad;
                  memory_reply_oe <= 1'b1;
                  state_q <= S_ACK;
               end
            end
            S_ACK: begin
               // the master ends the data phase by releasing the strobe
               if (!dtr) begin
                  memory_reply_oe <= 1'b0;
                  shared_lines_oe <= `SB_OE_NONE;
                  state_q <= S_IDLE;
               end
            end
            default: begin
               memory_reply_oe <= 1'b0;
               shared_lines_oe <= `SB_OE_NONE;
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-entry commit buffer, head registers are the output ports
   wire [BW-1:0] in_ent = pack(addr_q, op_q, merged);

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_valid <= 1'b0;
         wr_addr <= {AW{1'b0}};
         wr_be <= 2'h0;
         wr_data <= 16'h0000;
         tail_q <= {BW{1'b0}};
         tail_valid_q <= 1'b0;
      end else if (ce) begin
         if (pop && tail_valid_q) begin
            // tail moves to head; a push refills the tail
            {wr_addr, wr_be, wr_data} <= tail_q;
            if (push) begin
               tail_q <= in_ent;
            end else begin
               tail_valid_q <= 1'b0;
            end
         end else if (pop) begin
            // head emptied; a push takes its place directly
            wr_valid <= push;
            if (push) begin
               {wr_addr, wr_be, wr_data} <= in_ent;
            end
         end else if (push) begin
            // no pop: fill head first, then tail
            if (!wr_valid) begin
               {wr_addr, wr_be, wr_data} <= in_ent;
               wr_valid <= 1'b1;
            end else begin
               tail_q <= in_ent;
               tail_valid_q <= 1'b1;
            end
         end
      end
   end

endmodule // sub_bus_memory

// >>> mem_sva.sv
// Purpose: assertions on the memory end of the sub bus
// Assumes: bound to sub_bus_memory; strobes pass a two-stage sync
// Notes: the windows allow for that sync delay
`timescale 1ns/100ps
module mem_sva #(parameter AW = 6) (
   // clock and reset
   input wire clk_sys,
   input wire rstn,
   // bus side
   input wire address_phase_strobe_n,
   input wire data_strobe_n,
   input wire [23:0] shared_lines_o,
   input wire [23:0] shared_lines_oe,
   input wire memory_reply_oe,
   // commit stream
   input wire wr_valid,
   input wire wr_ready,
   input wire [AW-1:0] wr_addr,
   input wire [1:0] wr_be,
   input wire [15:0] wr_data,
   input wire parity_error
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   property p_oe; shared_lines_oe == 24'h000000 || shared_lines_oe == 24'h03ffff; endproperty
   a_oe: assert property (p_oe) else $error("line enable pattern");
   property p_par; shared_lines_oe[0] |-> shared_lines_o[16] == ~^shared_lines_o[7:0]
      && shared_lines_o[17] == ~^shared_lines_o[15:8]; endproperty
   a_par: assert property (p_par) else $error("read parity");
   // a reply needs a strobe held low long enough to cross the sync
   property p_cause; $rose(memory_reply_oe) |->
      !$past(address_phase_strobe_n, 3) || !$past(data_strobe_n, 3); endproperty
   a_cause: assert property (p_cause) else $error("reply without strobe");
   property p_drv; $rose(shared_lines_oe[0]) |-> !$past(data_strobe_n, 2); endproperty
   a_drv: assert property (p_drv) else $error("drive without data strobe");
   property p_drop; $rose(data_strobe_n) |->
      ##[1:6] (shared_lines_oe == 24'h000000 && !memory_reply_oe); endproperty
   a_drop: assert property (p_drop) else $error("reply or drive stuck");
   property p_pe; parity_error |=> !parity_error; endproperty
   a_pe: assert property (p_pe) else $error("parity flag too long");
   // head of the buffer stands while the user stalls
   property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data)
      && $stable(wr_addr) && $stable(wr_be); endproperty
   a_hold: assert property (p_hold) else $error("commit head changed");
   property p_be; wr_valid |-> wr_be != 2'h0; endproperty
   a_be: assert property (p_be) else $error("empty byte enable");
   c_wr: cover property ($rose(wr_valid));
   c_rd: cover property ($rose(shared_lines_oe[0]));
   c_pe: cover property (parity_error);
endmodule // mem_sva

// >>> sub_bus_master.sv
// Purpose: behavioural master (processor side) of the sub bus
// Assumes: sole master, so it always holds bus authority
// Notes: released lines show the inverse of the last value driven
`timescale 1ns/100ps
module sub_bus_master #(parameter TMO = 800) (
   // clock and reply as seen on the wire
   input wire clk_sys,
   input wire reply,
   input wire [23:0] lines_in,
   // strobes and lines driven
   output reg phase4_clk,
   output reg atr_n,
   output reg dtr_n,
   output reg fen_n,
   output reg bus_request_high_prio_n, // strapped to the high-priority line
   output reg [23:0] lines_q,
   // read result, one-cycle strobe
   output reg rd_stb,
   output reg [17:0] rd_word
);
   reg [2:0] div_q; // phase-four divider, runs free
   initial begin
      {phase4_clk, atr_n, dtr_n, fen_n, rd_stb, div_q} = 8'h70;
      bus_request_high_prio_n = 1'b1;
      lines_q = 24'h000000;
      rd_word = 18'h0;
   end
   always @(posedge clk_sys) begin
      div_q <= div_q + 3'h1;
      phase4_clk <= ~div_q[2];
   end
   // wait for the reply level, 4 us limit counted in cycles
   task wt(input v, output ok);
      integer n;
      begin
         ok = 1'b0;
         for (n = 0; n < TMO && !ok; n = n + 1) begin
            @(posedge clk_sys);
            ok = (reply === v);
         end
      end
   endtask
   task xfer(input [2:0] op, input [17:0] wa, input [17:0] wd, input fen,
             input [2:0] nz, output ok);
      reg done;
      begin
         @(posedge clk_sys);
         // sole master on the high-priority line: it always wins the fall
         bus_request_high_prio_n <= 1'b0;
         while (div_q != 3'h4) @(posedge clk_sys);
         atr_n <= 1'b0;
         fen_n <= ~fen;
         lines_q <= {wa[17:12], op, nz, wa[11:0]};
         wt(1'b1, ok);
         atr_n <= 1'b1;
         bus_request_high_prio_n <= 1'b1;
         fen_n <= 1'b1;
         lines_q <= ~lines_q;
         if (ok) begin
            wt(1'b0, done);
            // a linked function module may hold the data phase back
            repeat (nz) @(posedge clk_sys);
            dtr_n <= 1'b0;
            if (op[2]) lines_q[17:0] <= wd;
            wt(1'b1, ok);
            rd_word <= lines_in[17:0];
            rd_stb <= ok & ~op[2];
            dtr_n <= 1'b1;
            lines_q <= ~lines_q;
            @(posedge clk_sys) rd_stb <= 1'b0;
            wt(1'b0, done);
         end
      end
   endtask
endmodule // sub_bus_master

// >>> testbench.sv
// Purpose: self-checking bench for the sub bus memory end
// Assumes: one master model; commit stream drained at random
// Notes: drivers queue expected words, monitors pop them as results show
`timescale 1ns/100ps
module testbench;
   reg clk_sys, rstn, wr_ready, stall;
   integer seed, errors, compares, i, n, pe_exp, pe_cnt;
   reg [15:0] mem_q [0:63]; // reference storage
   reg [23:0] exp_wr [$];
   reg [23:0] exp_rd [$];
   wire phase4_clk, address_phase_strobe_n, data_strobe_n, function_strobe_n;
   wire memory_reply_oe, memory_reply_n_o, rd_stb, wr_valid, parity_error;
   wire bus_request_high_prio_n;
   wire [23:0] shared_lines_i, shared_lines_o, shared_lines_oe, mq;
   wire [17:0] rd_word;
   wire [5:0] wr_addr;
   wire [1:0] wr_be;
   wire [15:0] wr_data;
   // each line carries whoever enables it
   assign shared_lines_i = (shared_lines_oe & shared_lines_o) | (~shared_lines_oe & mq);
   sub_bus_memory u_sub_bus_memory (.clk_sys, .rstn, .ce(1'b1), .phase4_clk,
      .shared_lines_i, .shared_lines_o, .shared_lines_oe, .address_phase_strobe_n,
      .data_strobe_n, .function_strobe_n, .memory_reply_n_o, .memory_reply_oe,
      .wr_valid, .wr_ready, .wr_addr, .wr_be, .wr_data, .parity_error);
   sub_bus_master u_sub_bus_master (.clk_sys, .reply(memory_reply_oe & ~memory_reply_n_o),
      .lines_in(shared_lines_i), .phase4_clk, .atr_n(address_phase_strobe_n),
      .dtr_n(data_strobe_n), .fen_n(function_strobe_n), .lines_q(mq), .rd_stb, .rd_word,
      .bus_request_high_prio_n);
   always #2.5 clk_sys = ~clk_sys;
   task cmp(input [23:0] got, input [23:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // commit stream entry against the oldest write note
   task cmp_wr(input [23:0] got);
      begin
         cmp(got, exp_wr.size() ? exp_wr.pop_front() : 24'hx);
      end
   endtask
   // read word against the oldest read note
   task cmp_rd(input [23:0] got);
      begin
         cmp(got, exp_rd.size() ? exp_rd.pop_front() : 24'hx);
      end
   endtask
   task end_of_test;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task xf(input [2:0] op, input [17:0] wa, input [17:0] wd, input f, input exp);
      reg ok;
      begin
         u_sub_bus_master.xfer(op, wa, wd, f, 3'($random(seed)), ok);
         cmp({23'h0, ok}, {23'h0, exp});
      end
   endtask
   // byte writes keep the other stored byte; bad flips the lower parity
   task wr(input [1:0] code, input [5:0] a, input [15:0] d, input bad);
      begin
         if (code[0]) mem_q[a][7:0] = d[7:0];
         if (code[1]) mem_q[a][15:8] = d[15:8];
         exp_wr.push_back({a, code, mem_q[a]});
         pe_exp = pe_exp + bad;
         xf({1'b1, code}, {12'h000, a}, {~^d[15:8], bad ^ ~^d[7:0], d}, 1'b0, 1'b1);
      end
   endtask
   task rd(input [1:0] code, input [5:0] a);
      begin
         exp_rd.push_back({6'h00, ~^mem_q[a][15:8], ~^mem_q[a][7:0], mem_q[a]});
         xf({1'b0, code}, {12'h000, a}, 18'h0, 1'b0, 1'b1);
      end
   endtask
   ////////////////////////////////////////
   // monitors take the oldest note when a result shows
   always @(posedge clk_sys) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         cmp_wr({wr_addr, wr_be, wr_data});
      if (rd_stb === 1'b1)
         cmp_rd({6'h00, rd_word});
      if (parity_error === 1'b1)
         pe_cnt = pe_cnt + 1;
      wr_ready <= stall ? 1'b0 : 1'($random(seed));
   end
   initial begin
      {clk_sys, rstn, wr_ready, stall} = 4'h0;
      seed = 32'hffcc;
      {errors, compares, pe_exp, pe_cnt} = 128'h0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      for (i = 0; i < 8; i = i + 1) wr(2'h3, 6'(i * 9), 16'($random(seed)), 1'b0);
      for (i = 1; i < 3; i = i + 1) wr(2'(i), 6'h09, 16'($random(seed)), i == 2);
      for (i = 1; i < 4; i = i + 1) rd(2'(i), 6'h09);
      for (i = 0; i < 8; i = i + 1) rd(2'h3, 6'(i * 9));
      xf(3'h0, 18'h00001, 18'h0, 1'b0, 1'b0);
      xf(3'h4, 18'h00001, 18'h0, 1'b0, 1'b0);
      xf(3'h7, 18'h00040, 18'h0, 1'b0, 1'b0);
      xf(3'h3, 18'h20001, 18'h0, 1'b0, 1'b0);
      xf(3'h3, 18'h00001, 18'h0, 1'b1, 1'b0);
      // fill the two-entry buffer; the third write must wait for room
      stall <= 1'b1;
      wr(2'h3, 6'h01, 16'h1234, 1'b0);
      wr(2'h3, 6'h3f, 16'h5678, 1'b0);
      fork
         wr(2'h3, 6'h02, 16'hbeef, 1'b0);
         begin
            repeat (60) @(posedge clk_sys);
            // data strobe still waiting and the reply held off by the full buffer
            cmp({22'h0, data_strobe_n, memory_reply_oe}, 24'h0);
            stall <= 1'b0;
         end
      join
      for (n = 0; n < 2000 && exp_wr.size() != 0; n = n + 1) @(posedge clk_sys);
      cmp(24'(exp_wr.size() + exp_rd.size()), 24'h0);
      cmp(24'(pe_cnt), 24'(pe_exp));
      cmp({23'h0, bus_request_high_prio_n}, 24'h1);
      end_of_test;
   end
endmodule // testbench
bind sub_bus_memory mem_sva #(.AW(AW)) u_mem_sva (.clk_sys, .rstn, .address_phase_strobe_n,
   .data_strobe_n, .shared_lines_o, .shared_lines_oe, .memory_reply_oe, .wr_valid,
   .wr_ready, .wr_addr, .wr_be, .wr_data, .parity_error);
